// ===== rtl/card_sup_pkg.sv
package card_sup_pkg;
  // power sequencing states of the card supply
  typedef enum logic [1:0] {
    PWR_OFF,
    PWR_START,
    PWR_ON,
    PWR_DOWN
  } pwr_state_t;

  // status byte field positions
  localparam int unsigned ST_IDENT0 = 0;
  localparam int unsigned ST_IDENT1 = 1;
  localparam int unsigned ST_UNDERV = 2;
  localparam int unsigned ST_OVERLD = 3;
  localparam int unsigned ST_CARD = 4;
  localparam int unsigned ST_WIDTH = 8;

  // timing of the supply sequence
  localparam int unsigned CLK_MHZ = 125;
  localparam int unsigned STARTUP_US = 1;
  localparam int unsigned STARTUP_CYC = STARTUP_US * CLK_MHZ;
  localparam int unsigned DOWN_STEP_NS = 80;
  localparam int unsigned DOWN_STEP_CYC = (DOWN_STEP_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned CNT_W = 16;

  localparam logic [7:0] STATUS_RST = 8'h00;
endpackage

// ===== rtl/aux_line.sv
`timescale 1ns/1ps
// one open-drain auxiliary line with synchronised readback
module aux_line (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // control
  input wire logic sync_mode,
  input wire logic enable,
  input wire logic drive_level,
  // pin
  input wire logic pin_in,
  output logic pin_oe,
  // readback
  output logic level
);
  logic meta_reg;
  logic sync_reg;
  logic forced_reg;

  // two-flop synchroniser, pin comes from the card domain
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_reg <= 1'b1;
      sync_reg <= 1'b1;
    end else begin
      meta_reg <= pin_in;
      sync_reg <= meta_reg;
    end
  end

  // remember the level forced during a card write
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      forced_reg <= 1'b1;
    end else if (enable && sync_mode) begin
      forced_reg <= drive_level;
    end
  end

  // only pull low; high comes from the external pullup on the supply
  assign pin_oe = enable && sync_mode && !drive_level;

  // open pin reads one through the pullup, grounded reads zero
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      level <= 1'b1;
    end else begin
      level <= sync_mode ? forced_reg : sync_reg;
    end
  end
endmodule

// ===== rtl/card_supply_supervisor.sv
`timescale 1ns/1ps
// Summary of operation
// - supply undervoltage sets the undervoltage status flag while the supply is on (PWR_ON).
// - undervoltage causes no other action; converter keeps running unchanged.
// - overload stops converter, runs power-down sequence, sets overload fault flag.
// - first auxiliary line level returns in status bit 0.
// - second auxiliary line level returns in status bit 1.
// - auxiliary lines only pulled low; high comes from supply pullup.
// - asynchronous input reads zero when grounded, one when high or open.
// - synchronous mode reads back the level last forced by the device.
// - card clock output comes from the clock selector output.
// - card clock held low during supply startup and while supply off.
// - host picks fast or slow clock slope; device applies it.
// - chip select high blocks supply start, card clock, io, aux lines, fault clear and slope select; supply disable still acts, status keeps updating.
module card_supply_supervisor
  import card_sup_pkg::*;
#(
  parameter int unsigned STARTUP_CYCLES = STARTUP_CYC,
  parameter int unsigned DOWN_CYCLES = DOWN_STEP_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // host control
  input wire logic cs_n,
  input wire logic supply_enable,
  input wire logic sync_mode,
  input wire logic clk_slope_fast_sel,
  input wire logic fault_clear,
  input wire logic ident0_drive,
  input wire logic ident1_drive,
  // analog monitors (asynchronous)
  input wire logic supply_undervoltage_in,
  input wire logic supply_overload_in,
  input wire logic supply_good_in,
  input wire logic card_present,
  // clock selector
  input wire logic clk_sel_out,
  // card side
  output logic converter_on,
  output logic card_reset_out,
  output logic card_serial_hold_low,
  output logic card_clock_out,
  output logic card_clock_fast_slope,
  input wire logic aux_line_ident0_in,
  output logic aux_line_ident0_oe,
  input wire logic aux_line_ident1_in,
  output logic aux_line_ident1_oe,
  // status
  output logic supply_undervoltage_flag,
  output logic overload_fault,
  output logic [card_sup_pkg::ST_WIDTH-1:0] status_byte
);
  import card_sup_pkg::*;

  pwr_state_t state_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic [1:0] uv_sync_reg;
  logic [1:0] ol_sync_reg;
  logic [1:0] pg_sync_reg;
  logic [1:0] cs_sync_reg;
  logic [1:0] cd_sync_reg;
  logic active;
  logic id0_level;
  logic id1_level;
  logic clk_gate;

  // chip select low enables everything; pin is synchronised first
  assign active = !cs_sync_reg[1];

  // two-flop synchronisers for all asynchronous monitors
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      uv_sync_reg <= 2'h0;
      ol_sync_reg <= 2'h0;
      pg_sync_reg <= 2'h0;
      cs_sync_reg <= 2'h3;
      cd_sync_reg <= 2'h0;
    end else begin
      uv_sync_reg <= {uv_sync_reg[0], supply_undervoltage_in};
      ol_sync_reg <= {ol_sync_reg[0], supply_overload_in};
      pg_sync_reg <= {pg_sync_reg[0], supply_good_in};
      cs_sync_reg <= {cs_sync_reg[0], cs_n};
      cd_sync_reg <= {cd_sync_reg[0], card_present};
    end
  end

  // supply sequencing; undervoltage is deliberately not an input here
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= PWR_OFF;
      cnt_reg <= '0;
    end else begin
      unique case (state_reg)
        PWR_OFF: begin
          cnt_reg <= '0;
          if (active && supply_enable && !overload_fault) begin
            state_reg <= PWR_START;
          end
        end
        PWR_START: begin
          if (ol_sync_reg[1]) begin
            state_reg <= PWR_DOWN;
            cnt_reg <= '0;
          end else if (!supply_enable) begin
            state_reg <= PWR_DOWN;
            cnt_reg <= '0;
          end else if (cnt_reg >= CNT_W'(STARTUP_CYCLES - 1) && pg_sync_reg[1]) begin
            state_reg <= PWR_ON;
            cnt_reg <= '0;
          end else if (cnt_reg < CNT_W'(STARTUP_CYCLES - 1)) begin
            cnt_reg <= cnt_reg + 1'b1;
          end
        end
        PWR_ON: begin
          // a supply drop is only reported, never acted on
          if (ol_sync_reg[1] || !supply_enable) begin
            state_reg <= PWR_DOWN;
            cnt_reg <= '0;
          end
        end
        PWR_DOWN: begin
          // clock and io go low one cycle after entry; converter off after 3 * DOWN_CYCLES - 1 counts
          if (cnt_reg >= CNT_W'(3 * DOWN_CYCLES - 1)) begin
            state_reg <= PWR_OFF;
            cnt_reg <= '0;
          end else begin
            cnt_reg <= cnt_reg + 1'b1;
          end
        end
      endcase
    end
  end

  // overload fault is sticky; set wins over a host clear
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      overload_fault <= 1'b0;
    end else if (ol_sync_reg[1] && state_reg != PWR_OFF) begin
      overload_fault <= 1'b1;
    end else if (fault_clear && active) begin
      overload_fault <= 1'b0;
    end
  end

  // undervoltage flag follows the monitor while the supply is up
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      supply_undervoltage_flag <= 1'b0;
    end else begin
      supply_undervoltage_flag <= uv_sync_reg[1] && state_reg == PWR_ON;
    end
  end

  // power-down order: reset always low, clock and io drop one cycle after entry to PWR_DOWN, converter last
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      converter_on <= 1'b0;
      card_reset_out <= 1'b0;
      card_serial_hold_low <= 1'b1;
      clk_gate <= 1'b0;
    end else begin
      converter_on <= state_reg == PWR_START || state_reg == PWR_ON ||
        (state_reg == PWR_DOWN && cnt_reg < CNT_W'(3 * DOWN_CYCLES - 1));
      card_reset_out <= 1'b0;
      card_serial_hold_low <= !(state_reg == PWR_ON && active) ||
        (state_reg == PWR_DOWN && cnt_reg >= CNT_W'(2 * DOWN_CYCLES));
      clk_gate <= state_reg == PWR_ON && active;
    end
  end

  // clock from the selector, forced low unless supply is up and chip select is low
  assign card_clock_out = clk_sel_out && clk_gate;

  // slope setting latched while selected, kept otherwise
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      card_clock_fast_slope <= 1'b0;
    end else if (active) begin
      card_clock_fast_slope <= clk_slope_fast_sel;
    end
  end

  aux_line u_ident0 (
    .clk(clk),
    .arst_n(arst_n),
    .sync_mode(sync_mode),
    .enable(active && state_reg == PWR_ON),
    .drive_level(ident0_drive),
    .pin_in(aux_line_ident0_in),
    .pin_oe(aux_line_ident0_oe),
    .level(id0_level)
  );

  aux_line u_ident1 (
    .clk(clk),
    .arst_n(arst_n),
    .sync_mode(sync_mode),
    .enable(active && state_reg == PWR_ON),
    .drive_level(ident1_drive),
    .pin_in(aux_line_ident1_in),
    .pin_oe(aux_line_ident1_oe),
    .level(id1_level)
  );

  // status byte; upper bits are zero and carry no meaning for the host
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      status_byte <= STATUS_RST;
    end else begin
      status_byte <= STATUS_RST;
      status_byte[ST_IDENT0] <= id0_level;
      status_byte[ST_IDENT1] <= id1_level;
      status_byte[ST_UNDERV] <= supply_undervoltage_flag;
      status_byte[ST_OVERLD] <= overload_fault;
      status_byte[ST_CARD] <= cd_sync_reg[1];
    end
  end
endmodule

// ===== bench/card_sup_sva.sv
`timescale 1ns/1ps
// port-level checks of supply sequencing, aux lines and card clock
module card_sup_sva
  import card_sup_pkg::*;
#(
  parameter int unsigned STARTUP_CYCLES = STARTUP_CYC,
  parameter int unsigned DOWN_CYCLES = DOWN_STEP_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // block inputs
  input wire logic cs_n,
  input wire logic supply_enable,
  input wire logic clk_slope_fast_sel,
  input wire logic supply_undervoltage_in,
  input wire logic supply_overload_in,
  input wire logic clk_sel_out,
  // block outputs
  input wire logic converter_on,
  input wire logic card_serial_hold_low,
  input wire logic card_clock_out,
  input wire logic card_clock_fast_slope,
  input wire logic aux_line_ident0_oe,
  input wire logic aux_line_ident1_oe,
  input wire logic supply_undervoltage_flag,
  input wire logic overload_fault,
  input wire logic [card_sup_pkg::ST_WIDTH-1:0] status_byte
);
  // single domain, so clock and reset are given once
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  clk_src_a: assert property (card_clock_out |-> clk_sel_out)
    else $error("card clock not from selector");
  clk_off_a: assert property (!converter_on |-> !card_clock_out)
    else $error("card clock runs with supply off");
  start_low_a: assert property ($rose(converter_on) |-> !card_clock_out [*2])
    else $error("card clock runs in startup");
  ident0_low_a: assert property (aux_line_ident0_oe |-> ##[1:4] !status_byte[ST_IDENT0])
    else $error("ident0 low not in status");
  ident1_low_a: assert property (aux_line_ident1_oe |-> ##[1:4] !status_byte[ST_IDENT1])
    else $error("ident1 low not in status");
  desel_off_a: assert property (cs_n [*5] |-> !(aux_line_ident0_oe || aux_line_ident1_oe || card_clock_out))
    else $error("active while deselected");
  ovl_stop_a: assert property (supply_overload_in && converter_on |-> ##[1:5] overload_fault ##[1:40] !converter_on)
    else $error("overload not handled");
  uv_flag_a: assert property ((supply_undervoltage_in && !card_serial_hold_low) [*4] |-> supply_undervoltage_flag)
    else $error("undervoltage flag missing");
  uv_keep_a: assert property (supply_undervoltage_in && converter_on && supply_enable && !supply_overload_in
    && !overload_fault |=> converter_on)
    else $error("undervoltage stopped converter");
  fast_slope_a: assert property ((!cs_n && clk_slope_fast_sel) [*5] |-> card_clock_fast_slope)
    else $error("fast slope not applied");
  upper_zero_a: assert property (status_byte[7:5] == 3'h0)
    else $error("upper status bits set");
endmodule

bind card_supply_supervisor card_sup_sva #(.STARTUP_CYCLES(STARTUP_CYCLES), .DOWN_CYCLES(DOWN_CYCLES)) u_sva (.*);

// ===== bench/card_model.sv
`timescale 1ns/1ps
// card contacts on the aux lines, pulled up to the card supply
module card_model (
  // pull-down enables of the device
  input wire logic oe0,
  input wire logic oe1,
  // card grounds a contact when told
  input wire logic gnd0,
  input wire logic gnd1,
  // resolved line levels
  output logic pin0,
  output logic pin1
);
  // open drain: any pull-down wins, otherwise the pullup reads one
  assign pin0 = !(oe0 || gnd0);
  assign pin1 = !(oe1 || gnd1);
endmodule

// ===== bench/card_supply_supervisor_tb_top.sv
`timescale 1ns/1ps
module card_supply_supervisor_tb_top;
  import card_sup_pkg::*;
  logic clk, arst_n, cs_n, supply_enable, sync_mode, clk_slope_fast_sel, fault_clear, ident0_drive, ident1_drive;
  logic supply_undervoltage_in, supply_overload_in, supply_good_in, card_present, clk_sel_out, g0, g1;
  logic converter_on, card_reset_out, card_serial_hold_low, card_clock_out, card_clock_fast_slope;
  logic aux_line_ident0_in, aux_line_ident0_oe, aux_line_ident1_in, aux_line_ident1_oe;
  logic supply_undervoltage_flag, overload_fault;
  logic [ST_WIDTH-1:0] status_byte;
  logic [10:0] q[$];
  int n_errors = 0;
  int num_checks = 0;
  int seed = 42;
  event ev;

  // short counts keep the run brief
  card_supply_supervisor #(.STARTUP_CYCLES(4), .DOWN_CYCLES(2)) u_dut (.*);
  card_model u_card (.oe0(aux_line_ident0_oe), .oe1(aux_line_ident1_oe), .gnd0(g0), .gnd1(g1),
    .pin0(aux_line_ident0_in), .pin1(aux_line_ident1_in));

  // 125 MHz system clock
  initial begin
    clk = 0;
    forever #4 clk = ~clk;
  end

  // selector output wanders so the clock pin has something to pass
  always @(negedge clk) begin
    clk_sel_out <= 1'($random(seed));
  end

  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask

  // note the expectation; the monitor compares it
  task automatic chk(input logic [10:0] e);
    q.push_back(e);
    ->ev;
  endtask

  // oldest note against reset, serial hold, card bit, converter, flags, slope and low status bits
  always @(ev) begin
    num_checks++;
    if ({card_reset_out, card_serial_hold_low, status_byte[ST_CARD], converter_on, overload_fault,
        supply_undervoltage_flag, card_clock_fast_slope, status_byte[3:0]} !== q.pop_front()) begin
      n_errors++;
      $display("mismatch at %0t: status %h", $time, status_byte);
    end
  end

  task automatic report_and_stop;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // main sequence; the card is present until the deselected step removes it
  initial begin
    {arst_n, cs_n, supply_enable, sync_mode, clk_slope_fast_sel, fault_clear, ident0_drive, ident1_drive} = 8'h40;
    {supply_undervoltage_in, supply_overload_in, supply_good_in, g0, g1} = 5'h00;
    card_present = 1;
    wt(8);
    arst_n = 1;
    cs_n = 0;
    g0 = 1;
    wt(6);
    chk({3'h3, 8'h02});
    g0 = 0;
    g1 = 1;
    wt(6);
    chk({3'h3, 8'h01});
    g1 = 0;
    supply_enable = 1;
    supply_good_in = 1;
    wt(20);
    chk({3'h1, 8'h83});
    supply_undervoltage_in = 1;
    wt(6);
    chk({3'h1, 8'hA7});
    supply_undervoltage_in = 0;
    sync_mode = 1;
    // the card grounding a line must not show through in sync mode
    repeat (8) begin
      {clk_slope_fast_sel, g1, g0, ident1_drive, ident0_drive} = 5'($random(seed));
      wt(6);
      chk({3'h1, 3'h4, clk_slope_fast_sel, 2'h0, ident1_drive, ident0_drive});
    end
    {sync_mode, g0, g1, clk_slope_fast_sel} = 4'h0;
    wt(6);
    supply_overload_in = 1;
    wt(30);
    chk({3'h3, 8'h4B});
    supply_overload_in = 0;
    supply_enable = 0;
    fault_clear = 1;
    wt(4);
    fault_clear = 0;
    wt(4);
    chk({3'h3, 8'h03});
    // deselect first: the request must not slip through the chip select synchroniser
    cs_n = 1;
    card_present = 0;
    wt(4);
    supply_enable = 1;
    wt(20);
    chk({3'h2, 8'h03});
    // let the monitor take the last note before the run ends
    wt(2);
    report_and_stop();
  end

  // watchdog far beyond the under two hundred cycles the sequence needs
  initial begin
    #100000;
    n_errors++;
    report_and_stop();
  end
endmodule
